// ### dpsf_params.svh
// Constants for the dual-port semaphore flag port controller
`ifndef DPSF_PARAMS_SVH
`define DPSF_PARAMS_SVH
`define DPSF_FLAG_COUNT 8
`define DPSF_INDEX_WIDTH 3
`define DPSF_DATA_WIDTH 16
`define DPSF_CYCLE_NS 100
`define DPSF_ACCESS_NS 200
`define DPSF_ACCESS_CYCLES (((`DPSF_ACCESS_NS) + (`DPSF_CYCLE_NS) - 1) / (`DPSF_CYCLE_NS))
`define DPSF_CNT_WIDTH 4
`define DPSF_OP_FREE 2'h0
`define DPSF_OP_CLAIM 2'h1
`define DPSF_OP_INIT 2'h2
`endif

// ### dpsf_pkg.sv
// Types for the dual-port semaphore flag port controller
package dpsf_pkg;
	typedef enum logic [6:0] {
		DPSF_IDLE = 7'h01,
		DPSF_WSETUP = 7'h02,
		DPSF_WSTROBE = 7'h04,
		DPSF_GAP = 7'h08,
		DPSF_RSTROBE = 7'h10,
		DPSF_RDONE = 7'h20,
		DPSF_FINISH = 7'h40
	} dpsf_state_type;
endpackage

// ### dpsf_port_ctrl.sv
// Controller driving one port of the dual-port semaphore flags
`timescale 1ns/10ps
`include "dpsf_params.svh"
module dpsf_port_ctrl #(
	parameter int DATA_WIDTH = `DPSF_DATA_WIDTH,
	parameter int INDEX_WIDTH = `DPSF_INDEX_WIDTH
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// User command
	input wire logic cmd_valid_in,
	input wire logic [1:0] cmd_op_in,
	input wire logic [INDEX_WIDTH-1:0] cmd_index_in,
	input wire logic cmd_retry_in,
	output logic cmd_ready_out,
	output logic done_out,
	output logic granted_out,
	// Device pins
	output logic flag_space_select_n_out,
	output logic chip_enable_n_out,
	output logic output_enable_n_out,
	output logic write_n_out,
	output logic [INDEX_WIDTH-1:0] flag_index_lines_out,
	output logic [DATA_WIDTH-1:0] data_out,
	output logic data_oe_out,
	input wire logic [DATA_WIDTH-1:0] data_in
);
	// Strobe length rounded up to whole cycles so a slow device still meets its access time
	localparam logic [`DPSF_CNT_WIDTH-1:0] ACC = `DPSF_CNT_WIDTH'(`DPSF_ACCESS_CYCLES);

	// Sequencer
	dpsf_pkg::dpsf_state_type state;
	dpsf_pkg::dpsf_state_type next_state;
	logic [`DPSF_CNT_WIDTH-1:0] cnt;
	logic [`DPSF_CNT_WIDTH-1:0] next_cnt;
	logic [1:0] op;
	logic [1:0] next_op;
	logic [INDEX_WIDTH-1:0] idx;
	logic [INDEX_WIDTH-1:0] next_idx;
	logic retry;
	logic next_retry;
	logic wbit;
	logic next_wbit;

	// User handshake
	logic ready;
	logic next_ready;
	logic done;
	logic next_done;
	logic granted;
	logic next_granted;

	// Device strobes and write data
	logic sel_n;
	logic next_sel_n;
	logic oe_n;
	logic next_oe_n;
	logic we_n;
	logic next_we_n;
	logic doe;
	logic next_doe;
	logic [DATA_WIDTH-1:0] wdata;
	logic [DATA_WIDTH-1:0] next_wdata;

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_op = op;
		next_idx = idx;
		next_retry = retry;
		next_wbit = wbit;
		next_ready = ready;
		next_done = 1'b0;
		next_granted = granted;
		next_sel_n = sel_n;
		next_oe_n = oe_n;
		next_we_n = we_n;
		next_doe = doe;
		unique case (state)
			dpsf_pkg::DPSF_IDLE: begin
				// A command offered while busy is dropped without notice
				if (cmd_valid_in && ready) begin
					next_ready = 1'b0;
					next_op = cmd_op_in;
					next_retry = cmd_retry_in;
					next_idx = (cmd_op_in == `DPSF_OP_INIT) ? '0 : cmd_index_in;
					next_wbit = (cmd_op_in == `DPSF_OP_CLAIM) ? 1'b0 : 1'b1;
					next_sel_n = 1'b0;
					next_doe = 1'b1;
					next_cnt = '0;
					next_state = dpsf_pkg::DPSF_WSETUP;
				end
			end
			dpsf_pkg::DPSF_WSETUP: begin
				// Address and data settle one cycle before the strobe falls
				next_we_n = 1'b0;
				next_cnt = ACC;
				next_state = dpsf_pkg::DPSF_WSTROBE;
			end
			dpsf_pkg::DPSF_WSTROBE: begin
				if (cnt > 1) begin
					next_cnt = cnt - 1'b1;
				end else begin
					next_we_n = 1'b1;
					next_state = dpsf_pkg::DPSF_GAP;
				end
			end
			dpsf_pkg::DPSF_GAP: begin
				// Select drops between accesses so each read captures afresh
				next_doe = 1'b0;
				next_sel_n = 1'b1;
				if (!sel_n || doe) begin
					next_state = dpsf_pkg::DPSF_GAP;
				end else if (op == `DPSF_OP_CLAIM) begin
					next_sel_n = 1'b0;
					next_oe_n = 1'b0;
					next_cnt = ACC;
					next_state = dpsf_pkg::DPSF_RSTROBE;
				end else if (op == `DPSF_OP_INIT && idx != INDEX_WIDTH'(`DPSF_FLAG_COUNT - 1)) begin
					next_idx = idx + 1'b1;
					next_sel_n = 1'b0;
					next_doe = 1'b1;
					next_state = dpsf_pkg::DPSF_WSETUP;
				end else begin
					next_granted = 1'b0;
					next_state = dpsf_pkg::DPSF_FINISH;
				end
			end
			dpsf_pkg::DPSF_RSTROBE: begin
				if (cnt > 1) begin
					next_cnt = cnt - 1'b1;
				end else begin
					// Sample on the last strobe cycle, while the captured value still drives
					next_granted = ~data_in[0];
					next_oe_n = 1'b1;
					next_sel_n = 1'b1;
					next_state = dpsf_pkg::DPSF_RDONE;
				end
			end
			dpsf_pkg::DPSF_RDONE: begin
				if (!granted && retry) begin
					// Keep polling until the flag is handed over
					next_sel_n = 1'b0;
					next_oe_n = 1'b0;
					next_cnt = ACC;
					next_state = dpsf_pkg::DPSF_RSTROBE;
				end else begin
					next_state = dpsf_pkg::DPSF_FINISH;
				end
			end
			dpsf_pkg::DPSF_FINISH: begin
				// A failed claim without retry must be withdrawn by an explicit free
				next_done = 1'b1;
				next_ready = 1'b1;
				next_state = dpsf_pkg::DPSF_IDLE;
			end
			default: begin
				next_state = dpsf_pkg::DPSF_IDLE;
			end
		endcase
	end

	// Reset parks every strobe inactive so the device sees no access
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			state <= dpsf_pkg::DPSF_IDLE;
			cnt <= '0;
			op <= `DPSF_OP_FREE;
			idx <= '0;
			retry <= 1'b0;
			wbit <= 1'b1;
			ready <= 1'b1;
			done <= 1'b0;
			granted <= 1'b0;
			sel_n <= 1'b1;
			oe_n <= 1'b1;
			we_n <= 1'b1;
			doe <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			op <= next_op;
			idx <= next_idx;
			retry <= next_retry;
			wbit <= next_wbit;
			ready <= next_ready;
			done <= next_done;
			granted <= next_granted;
			sel_n <= next_sel_n;
			oe_n <= next_oe_n;
			we_n <= next_we_n;
			doe <= next_doe;
		end
	end

	// Every data pin has its own flop so the whole word changes on one edge; only bit zero carries the value
	always_comb begin
		next_wdata = '1;
		next_wdata[0] = next_wbit;
	end

	for (genvar b = 0; b < DATA_WIDTH; b++) begin : g_wdata
		always_ff @(posedge clk_in) begin
			if (reset_in) begin
				wdata[b] <= 1'b1;
			end else begin
				wdata[b] <= next_wdata[b];
			end
		end
	end

	assign cmd_ready_out = ready;
	assign done_out = done;
	assign granted_out = granted;
	assign flag_space_select_n_out = sel_n;
	// The array enable never asserts: this controller only reaches the flag space
	assign chip_enable_n_out = 1'b1;
	assign output_enable_n_out = oe_n;
	assign write_n_out = we_n;
	assign flag_index_lines_out = idx;
	assign data_out = wdata;
	assign data_oe_out = doe;
endmodule

// ### dpsf_port_ctrl_sva.sv
// Pin-level checks of the flag port controller
`timescale 1ns/10ps
module dpsf_port_ctrl_chk #(parameter int DATA_WIDTH = 16, parameter int INDEX_WIDTH = 3) (
	input wire logic clk_in, reset_in, cmd_valid_in, cmd_retry_in, cmd_ready_out, done_out, granted_out,
	input wire logic flag_space_select_n_out, chip_enable_n_out, output_enable_n_out, write_n_out, data_oe_out,
	input wire logic [1:0] cmd_op_in,
	input wire logic [INDEX_WIDTH-1:0] flag_index_lines_out,
	input wire logic [DATA_WIDTH-1:0] data_out, data_in
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	wire take = cmd_valid_in && cmd_ready_out;
	property p_grant;
		logic b;
		take && cmd_op_in == 2'h1 && !cmd_retry_in |-> ##7 (1, b = data_in[0]) ##3 done_out && granted_out == !b;
	endproperty
	a_ce_held: assert property (chip_enable_n_out) else $error("ce low");
	a_oe_select: assert property (!output_enable_n_out |-> !flag_space_select_n_out) else $error("oe");
	a_write_drive: assert property (!write_n_out |-> data_oe_out && !flag_space_select_n_out) else $error("we");
	a_write_value: assert property (take && cmd_op_in != 2'h2 |-> ##2 !write_n_out
		&& data_out[0] == ($past(cmd_op_in, 2) != 2'h1)) else $error("wr value");
	a_grant_read: assert property (p_grant) else $error("grant");
	a_poll_gap: assert property ($rose(output_enable_n_out) |-> flag_space_select_n_out) else $error("gap");
	a_index_hold: assert property (!flag_space_select_n_out && $past(flag_space_select_n_out) == 1'b0
		|-> $stable(flag_index_lines_out)) else $error("index");
	a_busy_take: assert property (take |=> !cmd_ready_out [*6]) else $error("busy");
	c_won: cover property (done_out && granted_out);
	c_lost: cover property (done_out && !granted_out);
	c_retry: cover property (take && cmd_retry_in);
endmodule
bind dpsf_port_ctrl dpsf_port_ctrl_chk #(.DATA_WIDTH(DATA_WIDTH), .INDEX_WIDTH(INDEX_WIDTH)) u_chk (.*);

// ### dpsf_sem_model.sv
// Behavioural flag device: left port on pins, right port from the bench
`timescale 1ns/10ps
module dpsf_sem_model (
	input wire logic sel_n, ce_n, oe_n, we_n, r_we, r_bit,
	input wire logic [2:0] idx, r_idx,
	input wire logic [15:0] din,
	output logic [15:0] dout,
	output logic r_flag
);
	// Power-up garbage: nothing clears the latches
	logic [7:0] rl = 8'hA5, rr = 8'h3C, ol = 8'h5A, orr = 8'h81;
	logic [15:0] q = 16'h0000;
	always @(posedge we_n) if (!sel_n && ce_n) rl[idx] <= din[0];
	always @(negedge r_we) rr[r_idx] <= r_bit;
	// Left wins a same-instant tie, so there is never a double owner
	always @(rl or rr) for (int k = 0; k < 8; k++) begin
		if (rl[k]) ol[k] = 1'b0;
		if (rr[k]) orr[k] = 1'b0;
		if (!ol[k] && !orr[k]) begin
			if (!rl[k]) ol[k] = 1'b1;
			else if (!rr[k]) orr[k] = 1'b1;
		end
	end
	always @(negedge sel_n or negedge oe_n) if (!sel_n && !oe_n) q = {16{~ol[idx]}};
	assign dout = (!sel_n && !oe_n) ? q : ~q;
	assign r_flag = ~orr[r_idx];
endmodule

// ### dpsf_port_ctrl_bench.sv
// Self-checking bench for the flag port controller
`timescale 1ns/10ps
module dpsf_port_ctrl_bench;
	logic clk_in = 0, reset_in = 1, cmd_valid_in = 0, cmd_retry_in = 0, r_we = 0, r_bit = 1;
	logic [1:0] cmd_op_in = 0;
	logic [2:0] cmd_index_in = 0, r_idx = 0, i, idx;
	logic sel_n, ce_n, oe_n, we_n, doe, rdy, done, gr;
	logic [15:0] dq, dd, dev;
	int mismatches = 0, samples_checked = 0, cyc = 0, seed = 32'h8F20;
	logic q[$];
	always #50 clk_in = ~clk_in;
	assign dd = doe ? dq : dev;
	dpsf_port_ctrl DUT (.clk_in(clk_in), .reset_in(reset_in), .cmd_valid_in(cmd_valid_in), .cmd_op_in(cmd_op_in),
		.cmd_index_in(cmd_index_in), .cmd_retry_in(cmd_retry_in), .cmd_ready_out(rdy), .done_out(done),
		.granted_out(gr), .flag_space_select_n_out(sel_n), .chip_enable_n_out(ce_n), .output_enable_n_out(oe_n),
		.write_n_out(we_n), .flag_index_lines_out(idx), .data_out(dq), .data_oe_out(doe), .data_in(dd));
	dpsf_sem_model dev_m (.sel_n(sel_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .r_we(r_we), .r_bit(r_bit),
		.idx(idx), .r_idx(r_idx), .din(dd), .dout(dev), .r_flag());
	task end_of_test;
		$display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task chk(input logic e, input logic g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("BAD granted exp %b got %b", e, g);
		end
	endtask
	task cmd(input logic [1:0] op, input logic [2:0] x, input logic rt, input logic e);
		while (rdy !== 1'b1) @(negedge clk_in);
		cmd_op_in = op;
		cmd_index_in = x;
		cmd_retry_in = rt;
		cmd_valid_in = 1;
		q.push_back(e);
		@(negedge clk_in) cmd_valid_in = 0;
	endtask
	task rw(input logic [2:0] x, input logic b);
		r_idx = x;
		r_bit = b;
		r_we = 1;
		@(negedge clk_in) r_we = 0;
		@(negedge clk_in);
	endtask
	always @(negedge clk_in) if (done === 1'b1) chk(q.pop_front(), gr);
	always @(posedge clk_in) if (++cyc > 3000) begin
		mismatches++;
		end_of_test;
	end
	initial begin
		repeat (6) @(posedge clk_in);
		@(negedge clk_in) reset_in = 0;
		cmd(2'h2, 3'h0, 0, 0);
		for (int k = 0; k < 8; k++) rw(3'(k), 1);
		i = 3'($random(seed));
		cmd(2'h1, i, 0, 1);
		// The right request must follow the settled claim, or it takes the flag first
		while (q.size() != 0) @(negedge clk_in);
		rw(i, 0);
		cmd(2'h0, i, 0, 0);
		cmd(2'h1, i, 0, 0);
		cmd(2'h1, i, 1, 1);
		repeat (30) @(negedge clk_in);
		rw(i, 1);
		cmd(2'h0, i, 0, 0);
		while (q.size() != 0) @(negedge clk_in);
		end_of_test;
	end
endmodule
